// file: src/asr_consts.svh
// Offsets, field positions and reset values of the serial receive error and interrupt block
//
// What this block does
// (RULE1) With parity enabled, check parity as a character enters the receive buffer.
// (RULE2) Even mode needs an even count of ones over data and parity; odd needs odd.
// (RULE3) Parity mismatch sets the parity error flag and the shared error factor.
// (RULE4) Writing 1 clears the parity error flag; writing 0 leaves it alone.
// (RULE5) After any error the character is still buffered and reception continues.
// (RULE6) A stop bit sampled as 0 sets the framing error flag and error factor.
// (RULE7) Writing 1 clears the framing error flag.
// (RULE8) A character arriving before the receive acknowledge sets overrun and error factor.
// (RULE9) Writing 1 clears the overrun error flag.
// (RULE10) An acknowledge in the same cycle as a buffer load counts as overrun.
// (RULE11) Three interrupt sources: transmit done, receive done, error; each flag and mask.
// (RULE12) Transmit done factor sets when the shift register finishes sending.
// (RULE13) CPU request only when factor, its mask and the CPU enable are all 1.
// (RULE14) Factors still set while masked; only the CPU request is held back.
// (RULE15) Each interrupt factor clears when software writes 1 to it.
// (RULE16) Receive done factor sets when a character enters the receive buffer.
// (RULE17) Receive done factor also sets on characters with parity or framing error.
// (RULE18) All three errors share one error factor; software reads the error flags.
// (RULE19) Software loads and starts the next transmit only after transmit done.
// (RULE20) Software reads the receive buffer only after receive done is raised.
// (RULE21) An overrun does not set the receive done factor.
// (RULE22) Writing receive enable to 0 stops reception and clears all three error flags.
// (RULE23) Framing, parity, overrun flags sit at bits 2, 1, 0 of one status register.
// (RULE24) Each error flag stays set on its own until software clears it.
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ASR_OFF_CTRL 8'h00
`define ASR_OFF_FMT 8'h04
`define ASR_OFF_ERR 8'h08
`define ASR_OFF_IFLAG 8'h0C
`define ASR_OFF_IMASK 8'h10
`define ASR_OFF_RXD 8'h14
`define ASR_OFF_TXD 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASR_CTRL_TX_EN 0
`define ASR_CTRL_TX_START 1
`define ASR_CTRL_RX_EN 2
`define ASR_CTRL_RX_ACK 3
`define ASR_FMT_CH7 0
`define ASR_FMT_ODD 2
`define ASR_FMT_PEN 3
`define ASR_ERR_OVR 0
`define ASR_ERR_PAR 1
`define ASR_ERR_FRM 2
`define ASR_IRQ_TX 0
`define ASR_IRQ_RX 1
`define ASR_IRQ_ERR 2
`define ASR_DATA_MSB 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASR_RST_FLAGS 3'h0
`define ASR_RST_BYTE 8'h00
`define ASR_RST_WORD 32'h0000_0000

`endif

// file: src/asr_pkg.sv
// Types shared by the serial receive error and interrupt block
package asr_pkg;

   // Bus slave phase, one-hot
   typedef enum logic [1:0] {
      ASR_BUS_IDLE = 2'b01,
      ASR_BUS_RESP = 2'b10
   } asr_bus_t;

   typedef logic [2:0] asr_flags_t;

endpackage

// file: src/asr_rx_err_irq.sv
// Receive error detection, interrupt factors and APB registers of the async serial port
`timescale 1ns/10ps
`include "asr_consts.svh"

module asr_rx_err_irq #(
   parameter int DATA_W = 8
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_irq_enable,
   input wire logic rx_char_done,
   input wire logic [DATA_W-1:0] rx_char_data,
   input wire logic rx_parity_bit,
   input wire logic rx_stop_bit,
   input wire logic tx_shift_done,
   input wire logic tx_busy,
   output logic transmit_enable,
   output logic receive_enable,
   output logic transmit_start_trigger,
   output logic [DATA_W-1:0] tx_char_data,
   output logic serial_irq
);

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   asr_pkg::asr_bus_t bus_q;
   asr_pkg::asr_bus_t bus_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pslverr_q;
   logic pslverr_d;
   logic acc;
   logic wr;
   logic hit;

   // Transfer completes on the edge where pready is already high
   assign acc = psel && penable && (bus_q == asr_pkg::ASR_BUS_RESP);
   assign wr = acc && pwrite;

   // Control and data state
   logic tx_en_q;
   logic tx_en_d;
   logic rx_en_q;
   logic rx_en_d;
   logic tx_start_q;
   logic tx_start_d;
   logic ch7_q;
   logic ch7_d;
   logic pen_q;
   logic pen_d;
   logic odd_q;
   logic odd_d;
   logic [DATA_W-1:0] txd_q;
   logic [DATA_W-1:0] txd_d;
   logic [DATA_W-1:0] rxbuf_q;
   logic [DATA_W-1:0] rxbuf_d;
   logic pend_q;
   logic pend_d;
   asr_pkg::asr_flags_t err_q;
   asr_pkg::asr_flags_t err_d;
   asr_pkg::asr_flags_t ifl_q;
   asr_pkg::asr_flags_t ifl_d;
   asr_pkg::asr_flags_t imask_q;
   asr_pkg::asr_flags_t imask_d;
   logic irq_q;
   logic irq_d;

   always_comb begin
      bus_d = bus_q;
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      hit = 1'b1;
      unique case (bus_q)
         asr_pkg::ASR_BUS_IDLE: begin
            if (psel && penable) begin
               bus_d = asr_pkg::ASR_BUS_RESP;
               prdata_d = `ASR_RST_WORD;
               unique case (paddr)
                  `ASR_OFF_CTRL: begin
                     prdata_d[`ASR_CTRL_TX_EN] = tx_en_q;
                     prdata_d[`ASR_CTRL_TX_START] = tx_busy | tx_start_q;
                     prdata_d[`ASR_CTRL_RX_EN] = rx_en_q;
                     prdata_d[`ASR_CTRL_RX_ACK] = pend_q;
                  end
                  `ASR_OFF_FMT: begin
                     prdata_d[`ASR_FMT_CH7] = ch7_q;
                     prdata_d[`ASR_FMT_ODD] = odd_q;
                     prdata_d[`ASR_FMT_PEN] = pen_q;
                  end
                  `ASR_OFF_ERR: prdata_d[2:0] = err_q; // [RULE23] [RULE18]
                  `ASR_OFF_IFLAG: prdata_d[2:0] = ifl_q;
                  `ASR_OFF_IMASK: prdata_d[2:0] = imask_q;
                  `ASR_OFF_RXD: prdata_d[DATA_W-1:0] = rxbuf_q;
                  `ASR_OFF_TXD: prdata_d[DATA_W-1:0] = txd_q;
                  default: hit = 1'b0;
               endcase
               pslverr_d = ~hit;
            end
         end
         asr_pkg::ASR_BUS_RESP: begin
            bus_d = asr_pkg::ASR_BUS_IDLE;
            pslverr_d = 1'b0;
         end
         default: bus_d = asr_pkg::ASR_BUS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bus_q <= asr_pkg::ASR_BUS_IDLE;
         prdata_q <= `ASR_RST_WORD;
         pslverr_q <= 1'b0;
      end else begin
         bus_q <= bus_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------
   // Configuration and triggers
   // ----------------------------------------
   logic wr_ctrl;
   logic ack_wr;

   assign wr_ctrl = wr && (paddr == `ASR_OFF_CTRL);
   assign ack_wr = wr_ctrl && pwdata[`ASR_CTRL_RX_ACK];

   always_comb begin
      tx_en_d = tx_en_q;
      rx_en_d = rx_en_q;
      ch7_d = ch7_q;
      pen_d = pen_q;
      odd_d = odd_q;
      txd_d = txd_q;
      imask_d = imask_q;
      tx_start_d = 1'b0;
      if (wr_ctrl) begin
         tx_en_d = pwdata[`ASR_CTRL_TX_EN];
         rx_en_d = pwdata[`ASR_CTRL_RX_EN];
         tx_start_d = pwdata[`ASR_CTRL_TX_START] & pwdata[`ASR_CTRL_TX_EN];
      end
      if (wr && (paddr == `ASR_OFF_FMT)) begin
         ch7_d = pwdata[`ASR_FMT_CH7];
         odd_d = pwdata[`ASR_FMT_ODD];
         pen_d = pwdata[`ASR_FMT_PEN];
      end
      if (wr && (paddr == `ASR_OFF_TXD)) begin
         txd_d = pwdata[DATA_W-1:0];
      end
      if (wr && (paddr == `ASR_OFF_IMASK)) begin
         imask_d = pwdata[2:0]; // [RULE11]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_en_q <= 1'b0;
         rx_en_q <= 1'b0;
         tx_start_q <= 1'b0;
         ch7_q <= 1'b0;
         pen_q <= 1'b0;
         odd_q <= 1'b0;
         txd_q <= DATA_W'(`ASR_RST_BYTE);
         imask_q <= `ASR_RST_FLAGS;
      end else begin
         tx_en_q <= tx_en_d;
         rx_en_q <= rx_en_d;
         tx_start_q <= tx_start_d;
         ch7_q <= ch7_d;
         pen_q <= pen_d;
         odd_q <= odd_d;
         txd_q <= txd_d;
         imask_q <= imask_d;
      end
   end

   // ----------------------------------------
   // Receive checks
   // ----------------------------------------
   logic rx_load;
   logic [DATA_W-1:0] rx_bits;
   logic par_err;
   logic frm_err;
   logic ovr_err;

   // Characters are only taken while reception is enabled
   assign rx_load = rx_char_done && rx_en_q;

   always_comb begin
      rx_bits = rx_char_data;
      if (ch7_q) begin
         rx_bits[`ASR_DATA_MSB] = 1'b0;
      end
   end

   // Odd total of ones is wanted exactly when odd mode is selected
   assign par_err = pen_q && ((^rx_bits ^ rx_parity_bit) != odd_q); // [RULE1] [RULE2]
   assign frm_err = ~rx_stop_bit; // [RULE6]
   assign ovr_err = pend_q || ack_wr; // [RULE8] [RULE10]

   // ----------------------------------------
   // Buffer, flags and interrupt request
   // ----------------------------------------
   asr_pkg::asr_flags_t err_set;
   asr_pkg::asr_flags_t ifl_set;
   asr_pkg::asr_flags_t err_clr;
   asr_pkg::asr_flags_t ifl_clr;

   always_comb begin
      err_set = `ASR_RST_FLAGS;
      err_set[`ASR_ERR_PAR] = rx_load && par_err; // [RULE3]
      err_set[`ASR_ERR_FRM] = rx_load && frm_err; // [RULE6]
      err_set[`ASR_ERR_OVR] = rx_load && ovr_err; // [RULE8] [RULE10]
      ifl_set = `ASR_RST_FLAGS;
      ifl_set[`ASR_IRQ_TX] = tx_shift_done; // [RULE12]
      ifl_set[`ASR_IRQ_RX] = rx_load && !ovr_err; // [RULE16] [RULE17] [RULE21]
      ifl_set[`ASR_IRQ_ERR] = |err_set; // [RULE18] [RULE3]
      err_clr = (wr && (paddr == `ASR_OFF_ERR)) ? pwdata[2:0] : `ASR_RST_FLAGS;
      ifl_clr = (wr && (paddr == `ASR_OFF_IFLAG)) ? pwdata[2:0] : `ASR_RST_FLAGS;
   end

   always_comb begin
      rxbuf_d = rxbuf_q;
      pend_d = pend_q;
      if (ack_wr) begin
         pend_d = 1'b0;
      end
      if (rx_load) begin
         rxbuf_d = rx_char_data; // [RULE5]
         pend_d = 1'b1;
      end
      if (!rx_en_q) begin
         pend_d = 1'b0;
      end
      // Set wins over a write-one clear; a zero leaves a flag alone
      err_d = (err_q & ~err_clr) | err_set; // [RULE4] [RULE7] [RULE9] [RULE24]
      ifl_d = (ifl_q & ~ifl_clr) | ifl_set; // [RULE15] [RULE14]
      if (wr_ctrl && !pwdata[`ASR_CTRL_RX_EN]) begin
         err_d = `ASR_RST_FLAGS; // [RULE22]
      end
      irq_d = cpu_irq_enable && |(ifl_q & imask_q); // [RULE13]
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rxbuf_q <= DATA_W'(`ASR_RST_BYTE);
         pend_q <= 1'b0;
         err_q <= `ASR_RST_FLAGS;
         ifl_q <= `ASR_RST_FLAGS;
         irq_q <= 1'b0;
      end else begin
         rxbuf_q <= rxbuf_d;
         pend_q <= pend_d;
         err_q <= err_d;
         ifl_q <= ifl_d;
         irq_q <= irq_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = bus_q[1];
   assign pslverr = pslverr_q;
   assign transmit_enable = tx_en_q;
   assign receive_enable = rx_en_q;
   assign transmit_start_trigger = tx_start_q;
   assign tx_char_data = txd_q;
   assign serial_irq = irq_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   logic no_disable;
   assign no_disable = !(wr_ctrl && !pwdata[`ASR_CTRL_RX_EN]);

   a_parity_flag_set: assert property (rx_load && par_err && no_disable // [RULE3]
      |=> err_q[`ASR_ERR_PAR] && ifl_q[`ASR_IRQ_ERR])
      else $error("parity error not flagged");

   a_parity_check_calc: assert property (rx_load && pen_q && no_disable // [RULE2]
      && ((^rx_bits ^ rx_parity_bit) == odd_q) && !err_q[`ASR_ERR_PAR]
      |=> !err_q[`ASR_ERR_PAR])
      else $error("parity flagged on matching character");

   a_framing_flag_set: assert property (rx_load && !rx_stop_bit && no_disable // [RULE6]
      |=> err_q[`ASR_ERR_FRM] && ifl_q[`ASR_IRQ_ERR])
      else $error("framing error not flagged");

   a_overrun_ack_race: assert property (rx_load && ack_wr && no_disable // [RULE10]
      |=> err_q[`ASR_ERR_OVR] && pend_q)
      else $error("coincident acknowledge not an overrun");

   a_overrun_no_rxdone: assert property (rx_load && pend_q && !ifl_q[`ASR_IRQ_RX] // [RULE21]
      && no_disable && !(wr && paddr == `ASR_OFF_IFLAG)
      |=> !ifl_q[`ASR_IRQ_RX] && err_q[`ASR_ERR_OVR])
      else $error("receive done raised on overrun");

   a_rxdone_set: assert property (rx_load && !ovr_err // [RULE16]
      |=> ifl_q[`ASR_IRQ_RX] && rxbuf_q == $past(rx_char_data))
      else $error("receive done or buffer load missing");

   a_err_w1c_clear: assert property (wr && paddr == `ASR_OFF_ERR && pwdata[`ASR_ERR_PAR] // [RULE4]
      && !err_set[`ASR_ERR_PAR] |=> !err_q[`ASR_ERR_PAR])
      else $error("parity flag not cleared by write of one");

   a_rx_off_clears: assert property (wr_ctrl && !pwdata[`ASR_CTRL_RX_EN] // [RULE22]
      |=> err_q == `ASR_RST_FLAGS && !receive_enable)
      else $error("receive disable left error flags");

   a_txdone_set: assert property (tx_shift_done // [RULE12]
      |=> ifl_q[`ASR_IRQ_TX])
      else $error("transmit done factor missing");

   a_irq_gating: assert property (##1 serial_irq // [RULE13]
      == $past(cpu_irq_enable && |(ifl_q & imask_q)))
      else $error("interrupt request mis-gated");

   a_bus_wait_one: assert property (psel && penable && !pready // pready high for one cycle after one wait cycle
      |=> pready ##1 !pready)
      else $error("bus answer not one cycle");

   a_framing_w1c_clear: assert property (wr && paddr == `ASR_OFF_ERR // [RULE7]
      && pwdata[`ASR_ERR_FRM] && !err_set[`ASR_ERR_FRM] |=> !err_q[`ASR_ERR_FRM])
      else $error("framing flag not cleared by write of one");

   a_overrun_w1c_clear: assert property (wr && paddr == `ASR_OFF_ERR // [RULE9]
      && pwdata[`ASR_ERR_OVR] && !err_set[`ASR_ERR_OVR] |=> !err_q[`ASR_ERR_OVR])
      else $error("overrun flag not cleared by write of one");

   a_err_write_zero: assert property (wr && paddr == `ASR_OFF_ERR // [RULE4]
      && !pwdata[`ASR_ERR_PAR] && err_q[`ASR_ERR_PAR] |=> err_q[`ASR_ERR_PAR])
      else $error("parity flag lost on write of zero");

   a_iflag_w1c_clear: assert property (wr && paddr == `ASR_OFF_IFLAG // [RULE15]
      && pwdata[`ASR_IRQ_RX] && !ifl_set[`ASR_IRQ_RX] |=> !ifl_q[`ASR_IRQ_RX])
      else $error("receive done factor not cleared by write of one");

   a_rxdone_on_error: assert property (rx_load && !ovr_err && (par_err || frm_err) // [RULE17]
      |=> ifl_q[`ASR_IRQ_RX])
      else $error("receive done missing on errored character");

   a_err_shared_factor: assert property (rx_load && ovr_err // [RULE18]
      |=> ifl_q[`ASR_IRQ_ERR])
      else $error("overrun did not raise the error factor");

   a_rx_off_refused: assert property (rx_char_done && !rx_en_q // [RULE22]
      |=> rxbuf_q == $past(rxbuf_q))
      else $error("character taken while reception is off");

   a_errors_sticky: assert property (err_q[`ASR_ERR_FRM] && !err_clr[`ASR_ERR_FRM] // [RULE24]
      && no_disable |=> err_q[`ASR_ERR_FRM])
      else $error("framing flag dropped without a clear");

   a_masked_factor_set: assert property (tx_shift_done && !imask_q[`ASR_IRQ_TX] // [RULE14]
      |=> ifl_q[`ASR_IRQ_TX])
      else $error("masked transmit done factor not set");

   a_irq_cpu_off: assert property (!cpu_irq_enable // [RULE13]
      |=> !serial_irq)
      else $error("interrupt request with CPU interrupts off");

endmodule // asr_rx_err_irq

// file: sim/asr_peer_model.sv
// Far side of the port: remote serial line seen as whole characters
`timescale 1ns/10ps

module asr_peer_model #(
   parameter int TX_CYC = 20
) (
   input wire logic core_clk,
   input wire logic transmit_start_trigger,
   output logic rx_char_done = 1'b0,
   output logic [7:0] rx_char_data = 8'hA5,
   output logic rx_parity_bit = 1'b0,
   output logic rx_stop_bit = 1'b1,
   output logic tx_shift_done = 1'b0,
   output logic tx_busy = 1'b0
);
   int cnt = 0;

   // ----------------------------------------
   // Receive: one character per call, lines scrambled after it
   // ----------------------------------------
   task automatic send(input logic [7:0] d, input logic p, input logic s);
      @(posedge core_clk);
      rx_char_done <= 1'b1;
      rx_char_data <= d;
      rx_parity_bit <= p;
      rx_stop_bit <= s;
      @(posedge core_clk);
      rx_char_done <= 1'b0;
      rx_char_data <= ~d;
      rx_parity_bit <= ~p;
      rx_stop_bit <= ~s;
   endtask

   // ----------------------------------------
   // Transmit: shift out for TX_CYC cycles after each start
   // ----------------------------------------
   always @(posedge core_clk) begin
      tx_shift_done <= 1'b0;
      if (transmit_start_trigger === 1'b1) begin
         tx_busy <= 1'b1;
         cnt <= TX_CYC;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         tx_busy <= 1'b0;
         tx_shift_done <= 1'b1;
      end
   end
endmodule // asr_peer_model

// file: sim/test_async_serial_rx_error_and_irq.sv
// Register-level testbench of the receive error and interrupt block
`timescale 1ns/10ps

module test_async_serial_rx_error_and_irq;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, cpu_irq_enable = 1'b0;
   logic rx_char_done, rx_parity_bit, rx_stop_bit, tx_shift_done, tx_busy;
   logic [7:0] rx_char_data, tx_char_data;
   logic transmit_enable, receive_enable, transmit_start_trigger, serial_irq;
   logic [31:0] r;
   logic e;
   int fail_count = 0;
   int total_checks = 0;
   int n;

   asr_rx_err_irq dut_u (.core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_irq_enable(cpu_irq_enable),
      .rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
      .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
      .tx_shift_done(tx_shift_done), .tx_busy(tx_busy), .transmit_enable(transmit_enable),
      .receive_enable(receive_enable), .transmit_start_trigger(transmit_start_trigger),
      .tx_char_data(tx_char_data), .serial_irq(serial_irq));

   asr_peer_model peer_u (.core_clk(core_clk), .transmit_start_trigger(transmit_start_trigger),
      .rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
      .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
      .tx_shift_done(tx_shift_done), .tx_busy(tx_busy));

   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
         fail_count++;
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         fail_count++;
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, r);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      rd("err_rst", 8'h08, 32'h0);
      rd("iflag_rst", 8'h0C, 32'h0);
      wr(8'h10, 32'h7);
      wr(8'h04, 32'h8);
      wr(8'h00, 32'h4);
      cpu_irq_enable <= 1'b1;
      peer_u.send(8'h03, 1'b0, 1'b1);
      rd("err_even_ok", 8'h08, 32'h0);
      rd("iflag_rx", 8'h0C, 32'h2);
      rd("rxd", 8'h14, 32'h3);
      wr(8'h0C, 32'h2);
      rd("iflag_w1c", 8'h0C, 32'h0);
      wr(8'h00, 32'hC);
      peer_u.send(8'h01, 1'b0, 1'b1);
      rd("err_par", 8'h08, 32'h2);
      rd("iflag_par", 8'h0C, 32'h6);
      chk("irq_on", 32'h1, {31'h0, serial_irq});
      rd("rxd_par", 8'h14, 32'h1);
      wr(8'h08, 32'h0);
      rd("err_w0", 8'h08, 32'h2);
      wr(8'h08, 32'h2);
      rd("err_w1", 8'h08, 32'h0);
      wr(8'h0C, 32'h7);
      wr(8'h04, 32'hC);
      wr(8'h00, 32'hC);
      peer_u.send(8'h01, 1'b0, 1'b1);
      rd("err_odd_ok", 8'h08, 32'h0);
      wr(8'h0C, 32'h7);
      peer_u.send(8'h80, 1'b0, 1'b0);
      rd("err_ovr_frm", 8'h08, 32'h5);
      rd("iflag_ovr", 8'h0C, 32'h4);
      rd("rxd_ovr", 8'h14, 32'h80);
      wr(8'h08, 32'h4);
      rd("err_frm_clr", 8'h08, 32'h1);
      wr(8'h08, 32'h1);
      rd("err_ovr_clr", 8'h08, 32'h0);
      peer_u.send(8'h00, 1'b1, 1'b1);
      rd("err_ovr2", 8'h08, 32'h1);
      wr(8'h00, 32'h0);
      rd("err_rxoff", 8'h08, 32'h0);
      peer_u.send(8'h55, 1'b0, 1'b1);
      rd("rxd_off", 8'h14, 32'h0);
      chk("rx_off", 32'h0, {31'h0, receive_enable});
      wr(8'h00, 32'h4);
      wr(8'h04, 32'h9);
      wr(8'h0C, 32'h7);
      chk("rx_on", 32'h1, {31'h0, receive_enable});
      // Acknowledge lands on the same edge as the buffer load
      fork
         wr(8'h00, 32'hC);
         begin
            repeat (2) @(posedge core_clk);
            peer_u.send(8'h81, 1'b1, 1'b1);
         end
      join
      rd("err_race", 8'h08, 32'h1);
      rd("iflag_race", 8'h0C, 32'h4);
      rd("ctrl_race", 8'h00, 32'hC);
      rd("rxd_7bit", 8'h14, 32'h81);
      wr(8'h0C, 32'h7);
      wr(8'h10, 32'h0);
      wr(8'h18, 32'h5A);
      wr(8'h00, 32'h3);
      rd("ctrl_tx", 8'h00, 32'h3);
      chk("tx_on", 32'h1, {31'h0, transmit_enable});
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (tx_shift_done !== 1'b1 && n < 100);
      chk("tx_done_seen", 32'h1, {31'h0, tx_shift_done});
      if (tx_shift_done !== 1'b1) begin
         results();
      end
      rd("iflag_tx", 8'h0C, 32'h1);
      chk("irq_masked", 32'h0, {31'h0, serial_irq});
      chk("txd", 32'h5A, {24'h0, tx_char_data});
      wr(8'h10, 32'h1);
      rd("imask", 8'h10, 32'h1);
      chk("irq_tx", 32'h1, {31'h0, serial_irq});
      cpu_irq_enable <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("irq_cpu_off", 32'h0, {31'h0, serial_irq});
      rd("unmapped", 8'h1C, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      results();
   end
endmodule // test_async_serial_rx_error_and_irq
